/* File: logic/limp_home_setpoint_defs.vh */
// Offsets, field positions, reset values and timing constants of the limp-home set-point registers.
// Assumes the serial frame decoder hands over a 6-bit register address and one data byte per access.
`ifndef LIMP_HOME_SETPOINT_DEFS_VH
`define LIMP_HOME_SETPOINT_DEFS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define FILT_REF_LOW_ADDR   6'h22
`define FILT_REF_HIGH_ADDR  6'h23
`define CH1_LEVEL_LOW_ADDR  6'h24
`define CH1_LEVEL_HIGH_ADDR 6'h25
`define CH2_LEVEL_LOW_ADDR  6'h26
`define CH2_LEVEL_HIGH_ADDR 6'h27
`define CH1_PW_LOW_ADDR     6'h28

// ----------------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------------
`define LOW_FIELD_MSB       1
`define REG_RESET           8'h00
`define CODE_RESET          10'h000

// ----------------------------------------------------------------------------
// Filter and PWM timing
// ----------------------------------------------------------------------------
`define FILT_SHIFT          4
`define FILT_WIDTH          14
`define PWM_DIV_WIDTH       8

`endif

/* File: logic/limp_home_setpoint_regs.v */
// Limp-home set-point register bank: filtered reference readback, analog level codes,
// channel 1 pulse width low byte, and the channel 1 internal PWM generator.
// Assumes a frame decoder outside drives one-cycle read and write strobes synchronous to clock,
// and a converter outside delivers 10-bit reference codes with a one-cycle valid strobe.
`timescale 1ns/10ps
`include "limp_home_setpoint_defs.vh"

module limp_home_setpoint_regs (
  input  wire                        clock,
  input  wire                        sys_rst,
  input  wire [5:0]                  reg_addr,
  input  wire                        reg_wr,
  input  wire                        reg_rd,
  input  wire [7:0]                  reg_wdata,
  output reg  [7:0]                  reg_rdata,
  output reg                         reg_hit,
  input  wire [9:0]                  reference_code,
  input  wire                        reference_valid,
  input  wire                        ch1_internal_pwm_select,
  input  wire [`PWM_DIV_WIDTH-1:0]   pwm_clock_divider,
  input  wire [1:0]                  ch1_pulse_width_msbs,
  input  wire                        ch1_external_dim,
  output reg  [9:0]                  ch1_analog_level_code,
  output reg  [9:0]                  ch2_analog_level_code,
  output reg  [7:0]                  ch1_pulse_width_low,
  output reg  [9:0]                  filtered_reference,
  output reg                         ch1_duty
);

  // ----------------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------------
  // One compare per register, used by the write strobes, reg_hit and the snapshot strobe; read data has its own case decode.
  wire hit_filt_low;
  wire hit_filt_high;
  wire hit_ch1_low;
  wire hit_ch1_high;
  wire hit_ch2_low;
  wire hit_ch2_high;
  wire hit_pw_low;
  wire hit_any;
  wire rd_filt_high;

  assign hit_filt_low  = (reg_addr == `FILT_REF_LOW_ADDR);
  assign hit_filt_high = (reg_addr == `FILT_REF_HIGH_ADDR);
  assign hit_ch1_low   = (reg_addr == `CH1_LEVEL_LOW_ADDR);
  assign hit_ch1_high  = (reg_addr == `CH1_LEVEL_HIGH_ADDR);
  assign hit_ch2_low   = (reg_addr == `CH2_LEVEL_LOW_ADDR);
  assign hit_ch2_high  = (reg_addr == `CH2_LEVEL_HIGH_ADDR);
  assign hit_pw_low    = (reg_addr == `CH1_PW_LOW_ADDR);
  assign hit_any       = hit_filt_low | hit_filt_high | hit_ch1_low | hit_ch1_high |
                         hit_ch2_low | hit_ch2_high | hit_pw_low;
  assign rd_filt_high  = reg_rd & hit_filt_high;

  // ----------------------------------------------------------------------------
  // Low-pass filter of the reference code
  // ----------------------------------------------------------------------------
  // Accumulator settles at 16 times the code, so the top ten bits are the filtered value.
  reg  [`FILT_WIDTH-1:0] filt_reg;
  reg  [`FILT_WIDTH-1:0] filt_next;
  reg  [9:0]             filt_out_next;
  wire [`FILT_WIDTH-1:0] filt_leak;
  wire [`FILT_WIDTH-1:0] filt_input;

  assign filt_leak  = filt_reg >> `FILT_SHIFT;
  assign filt_input = {{(`FILT_WIDTH-10){1'b0}}, reference_code};

  always @* begin
    filt_next     = filt_reg;
    filt_out_next = filtered_reference;
    if (reference_valid) begin
      filt_next     = filt_reg - filt_leak + filt_input;
      filt_out_next = filt_next[`FILT_WIDTH-1:`FILT_SHIFT];
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      filt_reg <= {`FILT_WIDTH{1'b0}};
    end else begin
      filt_reg <= filt_next;
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      filtered_reference <= `CODE_RESET;
    end else begin
      filtered_reference <= filt_out_next;
    end
  end

  // ----------------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------------
  // Writes to the two filtered reference addresses match no strobe here and are dropped.
  wire       wr_ch1_low;
  wire       wr_ch1_high;
  wire       wr_ch2_low;
  wire       wr_ch2_high;
  wire       wr_pw_low;
  wire [9:0] ch1_level_next;
  wire [9:0] ch2_level_next;
  reg  [7:0] pw_low_next;

  assign wr_ch1_low  = reg_wr & hit_ch1_low;
  assign wr_ch1_high = reg_wr & hit_ch1_high;
  assign wr_ch2_low  = reg_wr & hit_ch2_low;
  assign wr_ch2_high = reg_wr & hit_ch2_high;
  assign wr_pw_low   = reg_wr & hit_pw_low;

  split_code_next #(
    .CODE_WIDTH (10)
  ) ch1_level_split (
    .wr_low    (wr_ch1_low),
    .wr_high   (wr_ch1_high),
    .wdata     (reg_wdata),
    .code_cur  (ch1_analog_level_code),
    .code_next (ch1_level_next)
  );

  split_code_next #(
    .CODE_WIDTH (10)
  ) ch2_level_split (
    .wr_low    (wr_ch2_low),
    .wr_high   (wr_ch2_high),
    .wdata     (reg_wdata),
    .code_cur  (ch2_analog_level_code),
    .code_next (ch2_level_next)
  );

  always @* begin
    pw_low_next = ch1_pulse_width_low;
    if (wr_pw_low) begin
      pw_low_next = reg_wdata;
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ch1_analog_level_code <= `CODE_RESET;
    end else begin
      ch1_analog_level_code <= ch1_level_next;
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ch2_analog_level_code <= `CODE_RESET;
    end else begin
      ch2_analog_level_code <= ch2_level_next;
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ch1_pulse_width_low <= `REG_RESET;
    end else begin
      ch1_pulse_width_low <= pw_low_next;
    end
  end

  // ----------------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------------
  // The snapshot is taken from the same value that the high byte returns, never from a later sample.
  reg [1:0] lsb_snap_reg;
  reg [7:0] rdata_mux;
  reg [7:0] rdata_next;
  reg       hit_next;
  reg [1:0] lsb_snap_next;

  // Unmapped addresses read as zero so a host scanning the map sees no stale byte.
  always @* begin
    case (reg_addr)
      `FILT_REF_HIGH_ADDR:  rdata_mux = filtered_reference[9:2];
      `FILT_REF_LOW_ADDR:   rdata_mux = {6'h00, lsb_snap_reg};
      `CH1_LEVEL_LOW_ADDR:  rdata_mux = {6'h00, ch1_analog_level_code[1:0]};
      `CH1_LEVEL_HIGH_ADDR: rdata_mux = ch1_analog_level_code[9:2];
      `CH2_LEVEL_LOW_ADDR:  rdata_mux = {6'h00, ch2_analog_level_code[1:0]};
      `CH2_LEVEL_HIGH_ADDR: rdata_mux = ch2_analog_level_code[9:2];
      `CH1_PW_LOW_ADDR:     rdata_mux = ch1_pulse_width_low;
      default:              rdata_mux = `REG_RESET;
    endcase
  end

  always @* begin
    rdata_next    = reg_rdata;
    hit_next      = 1'b0;
    lsb_snap_next = lsb_snap_reg;
    if (reg_rd) begin
      rdata_next = rdata_mux;
      hit_next   = hit_any;
    end
    if (rd_filt_high) begin
      lsb_snap_next = filtered_reference[1:0];
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= `REG_RESET;
    end else begin
      reg_rdata <= rdata_next;
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_hit <= 1'b0;
    end else begin
      reg_hit <= hit_next;
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lsb_snap_reg <= 2'b00;
    end else begin
      lsb_snap_reg <= lsb_snap_next;
    end
  end

  // ----------------------------------------------------------------------------
  // Channel 1 internal PWM generator
  // ----------------------------------------------------------------------------
  // The divider stretches each count step to divider+1 clocks; a width of 0 gives zero duty.
  reg  [`PWM_DIV_WIDTH-1:0] div_cnt_reg;
  reg  [`PWM_DIV_WIDTH-1:0] div_cnt_next;
  reg  [9:0]                pwm_cnt_reg;
  reg  [9:0]                pwm_cnt_next;
  reg                       duty_next;
  wire [9:0]                ch1_width;
  wire                      div_wrap;

  assign ch1_width = {ch1_pulse_width_msbs, ch1_pulse_width_low};
  assign div_wrap  = (div_cnt_reg >= pwm_clock_divider);

  always @* begin
    div_cnt_next = div_cnt_reg + {{(`PWM_DIV_WIDTH-1){1'b0}}, 1'b1};
    pwm_cnt_next = pwm_cnt_reg;
    if (div_wrap) begin
      div_cnt_next = {`PWM_DIV_WIDTH{1'b0}};
      pwm_cnt_next = pwm_cnt_reg + 10'h001;
    end
  end

  always @* begin
    if (ch1_internal_pwm_select) begin
      duty_next = (pwm_cnt_reg < ch1_width);
    end else begin
      duty_next = ch1_external_dim;
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt_reg <= {`PWM_DIV_WIDTH{1'b0}};
    end else begin
      div_cnt_reg <= div_cnt_next;
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pwm_cnt_reg <= 10'h000;
    end else begin
      pwm_cnt_reg <= pwm_cnt_next;
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ch1_duty <= 1'b0;
    end else begin
      ch1_duty <= duty_next;
    end
  end

endmodule

// ----------------------------------------------------------------------------
// Next value of one split analog level code
// ----------------------------------------------------------------------------
// The low register carries only the bottom two code bits; the rest of its byte is dropped.
module split_code_next #(
  parameter CODE_WIDTH = 10
) (
  input  wire                  wr_low,
  input  wire                  wr_high,
  input  wire [7:0]            wdata,
  input  wire [CODE_WIDTH-1:0] code_cur,
  output reg  [CODE_WIDTH-1:0] code_next
);

  always @* begin
    code_next = code_cur;
    if (wr_low) begin
      code_next[CODE_WIDTH-9:0] = wdata[`LOW_FIELD_MSB:0];
    end
    if (wr_high) begin
      code_next[CODE_WIDTH-1:CODE_WIDTH-8] = wdata;
    end
  end

endmodule

/* File: test/limp_home_setpoint_props.sv */
// Checker for the set-point register port; watches top-level ports only.
// Assumes one clock domain and the async active-high reset.
`timescale 1ns/10ps
module limp_home_setpoint_props (
  input wire       clock, sys_rst, reg_wr, reg_rd, reg_hit, ch1_internal_pwm_select, ch1_external_dim, ch1_duty,
  input wire [5:0] reg_addr,
  input wire [7:0] reg_wdata, reg_rdata, ch1_pulse_width_low,
  input wire [9:0] ch1_analog_level_code, ch2_analog_level_code, filtered_reference
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Own copy of the captured low bits, taken at each high-byte read
  reg [1:0] snap_reg;
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) snap_reg <= 2'h0;
    else if (reg_rd && reg_addr == 6'h23) snap_reg <= filtered_reference[1:0];
  end
  sequence high_rd_s; reg_rd && reg_addr == 6'h23; endsequence
  sequence low_rd_s; reg_rd && reg_addr == 6'h22; endsequence
  high_byte_a: assert property (high_rd_s |=> reg_hit && reg_rdata == $past(filtered_reference[9:2]))
    else $error("high byte");
  low_pair_a: assert property (low_rd_s |=> reg_rdata == {6'h00, $past(snap_reg)}) else $error("low byte");
  unmapped_rd_a: assert property (reg_rd && (reg_addr < 6'h22 || reg_addr > 6'h28) |=> !reg_hit && reg_rdata == 8'h00)
    else $error("unmapped");
  level_reserved_a: assert property (reg_rd && (reg_addr == 6'h24 || reg_addr == 6'h26) |=> reg_rdata[7:2] == 6'h00)
    else $error("reserved");
  ch1_high_a: assert property (reg_wr && reg_addr == 6'h25 |=> ch1_analog_level_code[9:2] == $past(reg_wdata))
    else $error("ch1 high");
  ch2_low_a: assert property (reg_wr && reg_addr == 6'h26 |=> ch2_analog_level_code[1:0] == $past(reg_wdata[1:0]))
    else $error("ch2 low");
  pulse_low_a: assert property (reg_wr && reg_addr == 6'h28 |=> ch1_pulse_width_low == $past(reg_wdata))
    else $error("pulse width");
  ext_dim_a: assert property (!ch1_internal_pwm_select ##1 !ch1_internal_pwm_select |-> ch1_duty == $past(ch1_external_dim))
    else $error("dim");
endmodule
bind limp_home_setpoint_regs limp_home_setpoint_props checker_i (.clock, .sys_rst, .reg_wr, .reg_rd, .reg_hit,
  .ch1_internal_pwm_select, .ch1_external_dim, .ch1_duty, .reg_addr, .reg_wdata, .reg_rdata, .ch1_pulse_width_low,
  .ch1_analog_level_code, .ch2_analog_level_code, .filtered_reference);

/* File: test/reference_source.sv */
// Converter stand-in: a reference code with a valid pulse every second clock while run is high.
// Assumes the bench sets level and run at rising edges.
`timescale 1ns/10ps
module reference_source (
  input  wire       clock,
  input  wire       run,
  input  wire [9:0] level,
  output reg  [9:0] reference_code = 10'h000,
  output reg        reference_valid = 1'b0
);
  // Code is inverted between pulses so a stale value is never mistaken for a fresh one
  always @(posedge clock) begin
    reference_valid <= run && !reference_valid;
    reference_code <= (run && !reference_valid) ? level : ~level;
  end
endmodule

/* File: test/limp_home_setpoint_regs_tb_top.sv */
// Bench for the set-point registers: reset values, writes, filtered read pairing, PWM width.
// Assumes the converter stand-in beside the design; divider and width bits 9:8 driven by the bench.
`timescale 1ns/10ps
module limp_home_setpoint_regs_tb_top;
  reg        clock = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, sel = 1'b0, dim = 1'b0, run = 1'b0;
  reg  [5:0] reg_addr = 6'h00;
  reg  [7:0] reg_wdata = 8'h00;
  reg  [7:0] div = 8'h00;
  reg  [1:0] msbs = 2'h1;
  reg  [9:0] level = 10'h2d7;
  wire [7:0] reg_rdata, pw_low;
  wire       reg_hit, duty, valid;
  wire [9:0] code, c1, c2, filt;
  integer    fails = 0, checks_done = 0, cyc = 0, i, n;
  always #2 clock = ~clock;
  reference_source src (.clock(clock), .run(run), .level(level), .reference_code(code), .reference_valid(valid));
  limp_home_setpoint_regs uut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .reference_code(code),
    .reference_valid(valid), .ch1_internal_pwm_select(sel), .pwm_clock_divider(div), .ch1_pulse_width_msbs(msbs),
    .ch1_external_dim(dim), .ch1_analog_level_code(c1), .ch2_analog_level_code(c2), .ch1_pulse_width_low(pw_low),
    .filtered_reference(filt), .ch1_duty(duty));
  task chk(input [9:0] got, input [9:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [5:0] a, input [7:0] d);
    begin
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [5:0] a, input [7:0] e);
    begin
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 chk({2'h0, reg_rdata}, {2'h0, e});
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  // Whole run needs about 4550 cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      fails = fails + 1;
      conclude;
    end
  end
  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    for (i = 34; i <= 40; i = i + 1) rd(i[5:0], 8'h00);
    wr(6'h24, 8'hff);
    wr(6'h25, 8'ha5);
    wr(6'h26, 8'hfe);
    wr(6'h27, 8'h3c);
    wr(6'h28, 8'h5a);
    wr(6'h23, 8'hff);
    rd(6'h24, 8'h03);
    rd(6'h26, 8'h02);
    rd(6'h28, 8'h5a);
    rd(6'h25, 8'ha5);
    rd(6'h27, 8'h3c);
    rd(6'h3f, 8'h00);
    chk(c1, 10'h297);
    chk(c2, 10'h0f2);
    chk({2'h0, pw_low}, 10'h05a);
    @(posedge clock);
    run <= 1'b1;
    repeat (700) @(posedge clock);
    #1 chk(filt, 10'h2d7);
    rd(6'h23, 8'hb5);
    rd(6'h23, 8'hb5);
    @(posedge clock);
    level <= 10'h149;
    repeat (700) @(posedge clock);
    #1 chk(filt, 10'h149);
    rd(6'h22, 8'h03);
    rd(6'h23, 8'h52);
    rd(6'h22, 8'h01);
    @(posedge clock);
    dim <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk({9'h000, duty}, 10'h001);
    @(posedge clock);
    sel <= 1'b1;
    n = 0;
    repeat (3) @(posedge clock);
    repeat (1024) begin
      @(posedge clock);
      #1 n = n + duty;
    end
    chk(n[9:0], 10'h15a);
    @(posedge clock);
    div <= 8'h01;
    msbs <= 2'h0;
    n = 0;
    repeat (3) @(posedge clock);
    repeat (2048) begin
      @(posedge clock);
      #1 n = n + duty;
    end
    chk(n[9:0], 10'h0b4);
    conclude;
  end
endmodule
